// ===== logic/lsmseq_regs.vh
// Constants for the load/store multiple and move-string sequencer.
// Assumes a 32-entry register file with 32-bit registers, big-endian byte order.
`ifndef LSMSEQ_REGS_VH
`define LSMSEQ_REGS_VH
// Operation codes on i_op.
`define LSMSEQ_OP_LMW 3'h0
`define LSMSEQ_OP_STMW 3'h1
`define LSMSEQ_OP_LSI 3'h2
`define LSMSEQ_OP_LSX 3'h3
`define LSMSEQ_OP_STSI 3'h4
`define LSMSEQ_OP_STSX 3'h5
// Register count and string count field of integer_exception_reg (bits 25..31, big-endian).
`define LSMSEQ_NREGS 6'h20
`define LSMSEQ_IMM_ZERO_BYTES 7'h20
`define LSMSEQ_XER_CNT_HI 6
`define LSMSEQ_XER_CNT_LO 0
// Sequencer states.
`define LSMSEQ_ST_IDLE 2'h0
`define LSMSEQ_ST_RUN 2'h1
`define LSMSEQ_ST_WAIT 2'h2
`endif

// ===== logic/lsmseq_top.v
// Sequencer that breaks load/store multiple-word and move-string instructions
// into word and byte transfers between the register file and data memory.
// Assumes a data memory port with valid/ready request and a read-data strobe, and
// a register file with one read port (combinational) and one write port.
//
// Overview of operation
// [RULE1] A multiple-word load whose range covers the base register completes and loads it like the rest.
// [RULE2] Multiple-word loads and stores with an address not a multiple of four raise an alignment fault.
// [RULE3] The multiple-word load adds the displacement to the base (or zero) and fills registers dest..31.
// [RULE4] The multiple-word store adds the displacement to the base (or zero) and writes source..31 upward.
// [RULE5] String moves work at any byte alignment and never raise an alignment fault.
// [RULE6] An indexed string move with a zero count touches no memory and changes no register.
// [RULE7] A string load whose range covers the base register completes and loads it from memory.
// [RULE8] The immediate string load uses the base (or zero) as address and a count of zero means 32 bytes.
// [RULE9] String loads fill each register from its top byte down and wrap from register 31 to 0.
// [RULE10] A partly filled last register of a string load has its low unfilled bytes cleared.
// [RULE11] The indexed string load takes its count from the low seven count bits and fills ceil(n/4) registers.
// [RULE12] The indexed string load address is the base (or zero) plus the index register.
// [RULE13] String stores take bytes from each register top byte first and wrap from 31 to 0.
// [RULE14] Register indices run modulo 32 and transfers go out in ascending address order until done.
`include "lsmseq_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module lsmseq_top #(
   parameter BUF_DEPTH = 2
) (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_start,
   input wire [2:0] i_op,
   input wire [4:0] i_rt,
   input wire [4:0] i_ra,
   input wire [4:0] i_rb,
   input wire [15:0] i_disp,
   input wire [4:0] i_nb,
   input wire [31:0] i_xer,
   output wire o_busy,
   output reg o_done_ff,
   output reg o_align_err_ff,
   output wire [4:0] o_rf_raddr,
   input wire [31:0] i_rf_rdata,
   output reg o_rf_we_ff,
   output reg [4:0] o_rf_waddr_ff,
   output reg [31:0] o_rf_wdata_ff,
   output wire o_mem_valid,
   input wire i_mem_ready,
   output wire o_mem_write,
   output wire o_mem_byte,
   output wire [31:0] o_mem_addr,
   output wire [31:0] o_mem_wdata,
   input wire i_rdata_valid,
   output wire o_rdata_ready,
   input wire [31:0] i_rdata
);

   reg [1:0] state_ff;
   reg [1:0] nxt_state;
   reg is_load_ff;
   reg is_byte_ff;
   reg [31:0] addr_ff;
   reg [6:0] left_ff;    // Transfers (words or bytes) still to be issued.
   reg [6:0] pend_ff;    // Reads issued whose data is not yet written back.
   reg [4:0] rreg_ff;    // Register that the next store reads.
   reg [1:0] rbyte_ff;   // Byte lane that the next store takes.
   reg [4:0] wreg_ff;    // Register that load data fills.
   reg [1:0] wbyte_ff;
   reg [31:0] acc_ff;    // Assembles string bytes for one register.
   reg last_partial_ff;

   // Operand of the base register, zero when its field is zero.
   wire [31:0] base_val;
   wire [31:0] ea_d;
   wire [31:0] ea_x;
   wire [6:0] xer_n;
   assign xer_n = i_xer[`LSMSEQ_XER_CNT_HI:`LSMSEQ_XER_CNT_LO];

   // Start-time reads share the one read port: base the cycle after start, index is taken
   // via i_rb on the following cycle would cost latency, so the caller supplies
   // the base through the read port and the index register value in i_xer-free
   // form is not available; we therefore read base the cycle after start and index the cycle after that.
   reg [1:0] setup_ff;
   reg [31:0] base_ff;
   assign base_val = (i_ra == 5'h00) ? 32'h00000000 : i_rf_rdata;
   assign ea_d = base_ff + {{16{i_disp[15]}}, i_disp};            // [RULE3] [RULE4]
   assign ea_x = base_ff + i_rf_rdata;                            // [RULE12]

   function [6:0] words_for;
      input [6:0] n;
      begin
         words_for = (n + 7'h03) >> 2;
      end
   endfunction

   // Read port: base during setup, index on second setup cycle, else store source.
   assign o_rf_raddr = (setup_ff == 2'h1) ? i_ra : (setup_ff == 2'h2) ? i_rb : rreg_ff;

   wire issue;
   wire rd_room;
   // Compared at full parameter width so no bits of the depth are dropped.
   assign rd_room = ({25'h0000000, pend_ff} < BUF_DEPTH);        // Back-pressure from the buffer.
   assign o_mem_valid = (state_ff == `LSMSEQ_ST_RUN) && (left_ff != 7'h00) &&
                        (!is_load_ff || rd_room);
   assign issue = o_mem_valid && i_mem_ready;
   assign o_mem_write = !is_load_ff;
   assign o_mem_byte = is_byte_ff;
   assign o_mem_addr = addr_ff;
   // Store data sits in the low byte for string stores, top byte first. [RULE13]
   assign o_mem_wdata = is_byte_ff ?
      {24'h000000, i_rf_rdata[8'h1F - {3'h0, rbyte_ff, 3'h0} -: 8]} : i_rf_rdata;
   assign o_busy = (state_ff != `LSMSEQ_ST_IDLE) || (setup_ff != 2'h0);

   // Two-entry read-data buffer so a late write-back stall loses no word.
   reg [31:0] buf_ff [0:1];
   reg buf_wp_ff;
   reg buf_rp_ff;
   reg [1:0] buf_cnt_ff;
   wire buf_pop;
   assign o_rdata_ready = (buf_cnt_ff != 2'h2);
   assign buf_pop = (buf_cnt_ff != 2'h0);

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         buf_ff[0] <= 32'h00000000;
         buf_ff[1] <= 32'h00000000;
         buf_wp_ff <= 1'b0;
         buf_rp_ff <= 1'b0;
         buf_cnt_ff <= 2'h0;
      end else begin
         if (i_rdata_valid && o_rdata_ready) begin
            buf_ff[buf_wp_ff] <= i_rdata;
            buf_wp_ff <= ~buf_wp_ff;
         end
         if (buf_pop) begin
            buf_rp_ff <= ~buf_rp_ff;
         end
         buf_cnt_ff <= buf_cnt_ff + {1'b0, i_rdata_valid && o_rdata_ready} - {1'b0, buf_pop};
      end
   end

   wire [31:0] pop_data;
   assign pop_data = buf_ff[buf_rp_ff];
   wire [7:0] pop_byte;
   assign pop_byte = pop_data[7:0];
   wire [31:0] acc_next;
   // Bytes land from the top of the register downward. [RULE9]
   assign acc_next = acc_ff | ({pop_byte, 24'h000000} >> {wbyte_ff, 3'h0});

   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         `LSMSEQ_ST_IDLE: nxt_state = state_ff;
         `LSMSEQ_ST_RUN: begin
            if (left_ff == 7'h00 && pend_ff == 7'h00) begin
               nxt_state = `LSMSEQ_ST_IDLE;
            end
         end
         default: nxt_state = `LSMSEQ_ST_IDLE;
      endcase
   end

   reg [2:0] op_ff;
   reg [4:0] rt_ff;

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_ff <= `LSMSEQ_ST_IDLE;
         setup_ff <= 2'h0;
         op_ff <= 3'h0;
         rt_ff <= 5'h00;
         base_ff <= 32'h00000000;
         is_load_ff <= 1'b0;
         is_byte_ff <= 1'b0;
         addr_ff <= 32'h00000000;
         left_ff <= 7'h00;
         pend_ff <= 7'h00;
         rreg_ff <= 5'h00;
         rbyte_ff <= 2'h0;
         wreg_ff <= 5'h00;
         wbyte_ff <= 2'h0;
         acc_ff <= 32'h00000000;
         last_partial_ff <= 1'b0;
         o_done_ff <= 1'b0;
         o_align_err_ff <= 1'b0;
         o_rf_we_ff <= 1'b0;
         o_rf_waddr_ff <= 5'h00;
         o_rf_wdata_ff <= 32'h00000000;
      end else begin
         state_ff <= nxt_state;
         o_done_ff <= 1'b0;
         o_align_err_ff <= 1'b0;
         o_rf_we_ff <= 1'b0;
         // Setup phase: capture base, then form the address and counts.
         if (setup_ff == 2'h0 && state_ff == `LSMSEQ_ST_IDLE && i_start) begin
            setup_ff <= 2'h1;
            op_ff <= i_op;
            rt_ff <= i_rt;
         end else if (setup_ff == 2'h1) begin
            base_ff <= base_val;
            setup_ff <= 2'h2;
         end else if (setup_ff == 2'h2) begin
            setup_ff <= 2'h0;
            rreg_ff <= rt_ff;
            wreg_ff <= rt_ff;
            rbyte_ff <= 2'h0;
            wbyte_ff <= 2'h0;
            acc_ff <= 32'h00000000;
            pend_ff <= 7'h00;
            is_load_ff <= (op_ff == `LSMSEQ_OP_LMW) || (op_ff == `LSMSEQ_OP_LSI) ||
                          (op_ff == `LSMSEQ_OP_LSX);
            is_byte_ff <= (op_ff != `LSMSEQ_OP_LMW) && (op_ff != `LSMSEQ_OP_STMW);
            case (op_ff)
               `LSMSEQ_OP_LMW, `LSMSEQ_OP_STMW: begin
                  addr_ff <= ea_d;
                  left_ff <= {1'b0, `LSMSEQ_NREGS} - {2'h0, rt_ff};      // [RULE3] [RULE4]
                  if (ea_d[1:0] != 2'h0) begin
                     o_align_err_ff <= 1'b1;                             // [RULE2]
                     o_done_ff <= 1'b1;
                  end else begin
                     state_ff <= `LSMSEQ_ST_RUN;
                  end
               end
               `LSMSEQ_OP_LSI, `LSMSEQ_OP_STSI: begin
                  addr_ff <= base_ff;                                    // [RULE8] [RULE5]
                  left_ff <= (i_nb == 5'h00) ? `LSMSEQ_IMM_ZERO_BYTES : {2'h0, i_nb};
                  state_ff <= `LSMSEQ_ST_RUN;
               end
               default: begin
                  addr_ff <= ea_x;                                       // [RULE12] [RULE5]
                  left_ff <= xer_n;                                      // [RULE11]
                  if (xer_n == 7'h00) begin
                     o_done_ff <= 1'b1;                                  // [RULE6]
                  end else begin
                     state_ff <= `LSMSEQ_ST_RUN;
                  end
               end
            endcase
         end
         // Issue: one transfer per accepted request, ascending addresses. [RULE14]
         if (issue) begin
            left_ff <= left_ff - 7'h01;
            addr_ff <= addr_ff + (is_byte_ff ? 32'h00000001 : 32'h00000004);
            if (!is_byte_ff || rbyte_ff == 2'h3) begin
               rreg_ff <= rreg_ff + 5'h01;                               // [RULE13] [RULE14]
            end
            if (is_byte_ff) begin
               rbyte_ff <= rbyte_ff + 2'h1;
            end
            last_partial_ff <= (left_ff == 7'h01);
         end
         if (state_ff == `LSMSEQ_ST_RUN) begin
            pend_ff <= pend_ff + {6'h00, issue && is_load_ff} - {6'h00, buf_pop};
         end
         // Write-back: every register in range is written, the base included. [RULE1] [RULE7]
         if (buf_pop) begin
            if (!is_byte_ff) begin
               o_rf_we_ff <= 1'b1;
               o_rf_waddr_ff <= wreg_ff;
               o_rf_wdata_ff <= pop_data;
               wreg_ff <= wreg_ff + 5'h01;
            end else if (wbyte_ff == 2'h3 || (pend_ff == 7'h01 && left_ff == 7'h00)) begin
               // Unfilled low bytes stay zero in the accumulator. [RULE10]
               o_rf_we_ff <= 1'b1;
               o_rf_waddr_ff <= wreg_ff;
               o_rf_wdata_ff <= acc_next;
               wreg_ff <= wreg_ff + 5'h01;                               // [RULE9]
               wbyte_ff <= 2'h0;
               acc_ff <= 32'h00000000;
            end else begin
               acc_ff <= acc_next;
               wbyte_ff <= wbyte_ff + 2'h1;
            end
         end
         if (state_ff == `LSMSEQ_ST_RUN && nxt_state == `LSMSEQ_ST_IDLE) begin
            o_done_ff <= 1'b1;
         end
      end
   end

endmodule // lsmseq_top
`default_nettype wire

// ===== bench/lsmseq_top_monitor.sv
// Checker for the sequencer's memory request and completion behaviour.
// Assumes it is bound into lsmseq_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module lsmseq_top_monitor (
   input wire logic i_clk, i_rst_n, i_start, o_busy, o_done_ff, o_align_err_ff,
   input wire logic o_rf_we_ff, o_mem_valid, i_mem_ready, o_mem_byte, o_mem_write,
   input wire logic i_rdata_valid, o_rdata_ready,
   input wire logic [2:0] i_op,
   input wire logic [4:0] o_rf_waddr_ff,
   input wire logic [31:0] i_xer, o_mem_addr, o_mem_wdata
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   logic [31:0] last_ff;
   logic seen_ff;
   wire acc = o_mem_valid && i_mem_ready;
   // Remember the last accepted address; cleared between instructions so steps stay local.
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         seen_ff <= 1'b0;
         last_ff <= 32'h00000000;
      end else begin
         seen_ff <= o_busy && (seen_ff || acc);
         if (acc) last_ff <= o_mem_addr;
      end
   end
   chk_err_with_done: assert property (o_align_err_ff |-> o_done_ff)
      else $error("alignment fault without done");
   chk_word_aligned: assert property (o_mem_valid && !o_mem_byte |-> o_mem_addr[1:0] == 2'h0)
      else $error("word request off a four byte boundary");
   chk_err_no_mem: assert property (o_align_err_ff |-> !seen_ff && !acc)
      else $error("faulted instruction moved data");
   chk_string_no_err: assert property (i_start && !o_busy && i_op >= 3'h2 |=> !o_align_err_ff [*6])
      else $error("string move raised alignment fault");
   chk_zero_quiet: assert property (i_start && !o_busy && i_op[0] && i_op != 3'h1 && i_xer[6:0] == 7'h00
      |-> !o_mem_valid throughout (##[1:5] o_done_ff))
      else $error("zero count indexed move touched memory");
   chk_addr_step: assert property (acc && seen_ff |-> o_mem_addr == last_ff + (o_mem_byte ? 32'h1 : 32'h4))
      else $error("request address not the next in order");
   chk_req_hold: assert property (o_mem_valid && !i_mem_ready
      |=> o_mem_valid && $stable(o_mem_addr) && $stable(o_mem_wdata) && $stable(o_mem_write))
      else $error("request changed before acceptance");
   chk_idle_no_req: assert property (!o_busy |-> !o_mem_valid)
      else $error("request while idle");
   chk_start_busy: assert property (i_start && !o_busy |=> o_busy)
      else $error("start not taken");
   cov_align_err: cover property (o_align_err_ff);
   cov_wrap_write: cover property (o_rf_we_ff && o_rf_waddr_ff == 5'h00);
   cov_req_stall: cover property (o_mem_valid && !i_mem_ready);
   cov_buf_full: cover property (i_rdata_valid && !o_rdata_ready);
endmodule // lsmseq_top_monitor
bind lsmseq_top lsmseq_top_monitor i_mon (.*);
`default_nettype wire

// ===== bench/lsmseq_mem_model.sv
// Data memory model: 256 byte big-endian memory, in-order read returns, stalls.
// Assumes the bench changes the stall bits at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module lsmseq_mem_model (
   input wire logic i_clk, i_rst_n, i_valid, i_write, i_byte, i_rd_ready,
   input wire logic [1:0] i_stall,
   input wire logic [31:0] i_addr, i_wdata,
   output logic o_ready, o_rvalid,
   output logic [31:0] o_rdata
);
   logic [7:0] mem [256];
   logic [31:0] q [$];
   logic took;
   logic [7:0] a;
   // Known contents; addresses wrap at 256 so any base value works.
   initial begin
      for (int k = 0; k < 256; k++) mem[k] = 8'(k * 37 + 17);
      {o_ready, o_rvalid, o_rdata, took} = 35'h0;
   end
   // Requests and returns are taken at the rising edge only.
   always @(posedge i_clk) begin
      a = i_addr[7:0];
      took = o_rvalid && i_rd_ready;
      if (!i_rst_n) q.delete();
      else if (took) void'(q.pop_front());
      if (i_valid && o_ready && i_write && i_byte) mem[a] = i_wdata[7:0];
      else if (i_valid && o_ready && i_write) {mem[a], mem[a + 8'h1], mem[a + 8'h2], mem[a + 8'h3]} = i_wdata;
      else if (i_valid && o_ready) q.push_back(i_byte ? {~{3{mem[a]}}, mem[a]}
         : {mem[a], mem[a + 8'h1], mem[a + 8'h2], mem[a + 8'h3]});
   end
   // Read data, once offered, stays until taken; idle data is scrambled, not held.
   always @(negedge i_clk) begin
      o_ready <= i_rst_n && !i_stall[0];
      o_rvalid <= i_rst_n && q.size() > 0 && ((o_rvalid && !took) || !i_stall[1]);
      o_rdata <= (q.size() > 0) ? q[0] : ~o_rdata;
   end
endmodule // lsmseq_mem_model
`default_nettype wire

// ===== bench/lsmseq_top_bench.sv
// Self-checking bench for the load/store multiple and string sequencer.
// Assumes lsmseq_top, the memory model and the bound monitor are compiled.
`timescale 1ns/1ps
`default_nettype none
module lsmseq_top_bench;
   logic i_clk = 1'b0, i_rst_n = 1'b0, i_start = 1'b0;
   logic [2:0] i_op = 3'h0;
   logic [4:0] i_rt = 5'h00, i_ra = 5'h00, i_rb = 5'h00, i_nb = 5'h00;
   logic [15:0] i_disp = 16'h0000;
   logic [31:0] i_xer = 32'h0, lf = 32'h28;
   logic [1:0] stall = 2'h0;
   wire o_busy, o_done_ff, o_align_err_ff, o_rf_we_ff, o_mem_valid, i_mem_ready;
   wire o_mem_write, o_mem_byte, i_rdata_valid, o_rdata_ready;
   wire [4:0] o_rf_raddr, o_rf_waddr_ff;
   wire [31:0] o_rf_wdata_ff, o_mem_addr, o_mem_wdata, i_rdata, i_rf_rdata;
   logic [31:0] rf [32], erf [32];
   logic [7:0] emem [256];
   int miscompares = 0, compares = 0, acc = 0, cyc = 0;
   // The register file answers reads at once.
   assign i_rf_rdata = rf[o_rf_raddr];
   lsmseq_top i_dut (.*);
   lsmseq_mem_model i_mem (.i_clk, .i_rst_n, .i_valid(o_mem_valid), .i_write(o_mem_write),
      .i_byte(o_mem_byte), .i_rd_ready(o_rdata_ready), .i_stall(stall), .i_addr(o_mem_addr),
      .i_wdata(o_mem_wdata), .o_ready(i_mem_ready), .o_rvalid(i_rdata_valid), .o_rdata(i_rdata));
   function automatic logic [31:0] nxt_lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   initial forever #12.5 i_clk = ~i_clk;
   // Write-back, access count and hang guard.
   always @(posedge i_clk) begin
      if (o_rf_we_ff) rf[o_rf_waddr_ff] <= o_rf_wdata_ff;
      if (o_mem_valid && i_mem_ready) acc++;
      cyc++;
      if (cyc == 60000) begin
         miscompares++;
         finish_test();
      end
   end
   // Stalls are redrawn every cycle so requests and read returns stall at random.
   always @(negedge i_clk) begin
      lf <= nxt_lfsr(lf);
      stall <= lf[1:0];
   end
   task automatic chk(input logic [31:0] g, e);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic finish_test();
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // One instruction: predict registers and memory byte by byte, run, compare all.
   task automatic run(input logic [2:0] op, input logic [4:0] rt, ra, rb, nb,
      input logic [15:0] d, input logic [31:0] x);
      logic [31:0] ea;
      int n, k, t;
      logic ld, err;
      ea = (ra == 5'h00) ? 32'h0 : rf[ra];
      if (op <= 3'h1) ea = ea + {{16{d[15]}}, d};
      else if (op[0]) ea = ea + rf[rb];
      n = (op <= 3'h1) ? (32 - rt) * 4 : (op[0] ? x[6:0] : ((nb == 5'h00) ? 32 : nb));
      err = (op <= 3'h1) && (ea[1:0] != 2'h0);
      ld = (op == 3'h0) || (op == 3'h2) || (op == 3'h3);
      erf = rf;
      emem = i_mem.mem;
      for (k = 0; k < n && !err; k++) begin
         t = 31 - 8 * (k % 4);
         if (ld && k % 4 == 0) erf[(rt + k / 4) % 32] = 32'h0;
         if (ld) erf[(rt + k / 4) % 32][t -: 8] = emem[(ea + k) % 256];
         else emem[(ea + k) % 256] = rf[(rt + k / 4) % 32][t -: 8];
      end
      @(negedge i_clk);
      {i_op, i_rt, i_ra, i_rb, i_nb, i_disp, i_xer} = {op, rt, ra, rb, nb, d, x};
      i_start = 1'b1;
      acc = 0;
      @(negedge i_clk);
      i_start = 1'b0;
      for (t = 0; t < 3000 && o_done_ff !== 1'b1; t++) @(negedge i_clk);
      chk(o_done_ff, 1'b1);
      chk(o_align_err_ff, err);
      chk(acc, err ? 0 : (op <= 3'h1 ? n / 4 : n));
      @(negedge i_clk);
      for (k = 0; k < 32; k++) chk(rf[k], erf[k]);
      for (k = 0; k < 256; k++) chk(i_mem.mem[k], emem[k]);
   endtask
   // Corner cases first, then random instructions.
   initial begin
      for (int k = 0; k < 32; k++) rf[k] = 32'h9E3779B9 * k + 32'h28;
      rf[30] = 32'h00000040;
      rf[31] = 32'h00000083;
      rf[5] = 32'h00000001;
      repeat (8) @(posedge i_clk);
      @(negedge i_clk);
      i_rst_n = 1'b1;
      run(3'h0, 5'h1D, 5'h1E, 5'h00, 5'h00, 16'hFFF8, 32'h0);
      run(3'h0, 5'h14, 5'h00, 5'h00, 5'h00, 16'h0002, 32'h0);
      run(3'h1, 5'h1C, 5'h00, 5'h00, 5'h00, 16'h0010, 32'h0);
      run(3'h1, 5'h1C, 5'h1F, 5'h00, 5'h00, 16'h0000, 32'h0);
      run(3'h2, 5'h1E, 5'h1F, 5'h00, 5'h00, 16'h0000, 32'h0);
      run(3'h3, 5'h07, 5'h00, 5'h05, 5'h00, 16'h0000, 32'h0);
      run(3'h3, 5'h1F, 5'h1F, 5'h05, 5'h00, 16'h0000, 32'h5);
      run(3'h4, 5'h1F, 5'h00, 5'h00, 5'h07, 16'h0000, 32'h0);
      run(3'h5, 5'h02, 5'h00, 5'h05, 5'h00, 16'h0000, 32'h0);
      run(3'h5, 5'h03, 5'h1E, 5'h05, 5'h00, 16'h0000, 32'h9);
      repeat (16) run(lf[2:0] % 3'h6, lf[9:5], lf[14:10], lf[19:15], lf[24:20],
         lf[31:16], {25'h0, lf[6:0]});
      finish_test();
   end
endmodule // lsmseq_top_bench
`default_nettype wire
